// file: plr_far_terminal.sv
// Behavioural far terminal that feeds packet descriptors to the restart block
`timescale 1ns/1ps
module plr_far_terminal
  import plr_pkg::*;
(
  input  wire logic       clk_sys,      // System clock
  input  wire logic       sendRestart,  // Restart indication from the block
  input  wire logic       autoConfirm,  // Answer indications with a confirmation
  input  wire logic [3:0] answerDelay,  // Cycles before answering
  output logic            pktValid,     // Descriptor strobe
  output logic [7:0]      pktLen,       // Length in octets
  output logic [3:0]      pktGroup,     // Channel group
  output logic [7:0]      pktChan,      // Channel number
  output logic [1:0]      pktType,      // Packet kind
  output logic [6:0]      pktFlags      // Fault flags of the descriptor
);
  initial
  begin
    pktValid = 1'b0;
    pktLen   = 8'h00;
    pktGroup = 4'h0;
    pktChan  = 8'h00;
    pktType  = 2'h0;
    pktFlags = 7'h00;
  end

  task automatic send(input logic [7:0] len, input logic [3:0] grp, input logic [7:0] ch,
                      input logic [1:0] typ, input logic [6:0] flg);
    @(posedge clk_sys);
    pktValid <= 1'b1;
    pktLen   <= len;
    pktGroup <= grp;
    pktChan  <= ch;
    pktType  <= typ;
    pktFlags <= flg;
    @(posedge clk_sys);
    pktValid <= 1'b0;
    // Released fields flip so a stale descriptor cannot pass for a new one
    pktLen   <= ~len;
    pktGroup <= ~grp;
    pktChan  <= ~ch;
    pktType  <= ~typ;
    pktFlags <= ~flg;
  endtask

  // Answers a restart indication the way the peer procedure does
  initial
  begin
    forever
    begin
      @(posedge clk_sys);
      #1;
      if (autoConfirm && sendRestart)
      begin
        repeat (answerDelay) @(posedge clk_sys);
        send(8'h03, 4'h0, 8'h00, PLR_PKT_RESTART_CONF, 7'h00);
      end
    end
  end
endmodule

// file: plr_pkg.sv
// Types shared by the packet-layer restart block
package plr_pkg;

  typedef enum logic [2:0]
  {
    PLR_READY     = 3'b001,
    PLR_FAR_PEND  = 3'b010,
    PLR_LOCAL_PEND = 3'b100
  } plr_state_t;

  typedef enum logic [3:0]
  {
    PLR_ACT_NONE  = 4'b0001,
    PLR_ACT_DROP  = 4'b0010,
    PLR_ACT_PASS  = 4'b0100,
    PLR_ACT_FAULT = 4'b1000
  } plr_action_t;

  typedef enum logic [1:0]
  {
    PLR_PKT_RESTART_REQ  = 2'h0,
    PLR_PKT_RESTART_CONF = 2'h1,
    PLR_PKT_OTHER        = 2'h2
  } plr_pkt_t;

endpackage

// file: plr_restart_fsm.sv
// Receive screening, restart state machine and supervision timers of the packet layer
`timescale 1ns/1ps
`include "plr_restart_map.svh"

module plr_restart_fsm
  import plr_pkg::*;
#(
  parameter int unsigned RESTART_CYCLES = `PLR_RESTART_TIME_MS * (`PLR_CLK_HZ / 1000),
  parameter int unsigned CLEAR_CYCLES   = `PLR_CLEAR_TIME_MS * (`PLR_CLK_HZ / 1000),
  parameter int unsigned RESET_CYCLES   = `PLR_RESET_TIME_MS * (`PLR_CLK_HZ / 1000),
  parameter logic [7:0]  CONGESTION_CAUSE = 8'h05
)
(
  input  wire logic       clk_sys,          // System clock, 25 MHz
  input  wire logic       reset,            // Synchronous reset, active high
  input  wire logic       pktValid,         // One-cycle strobe, packet descriptor valid
  input  wire logic [7:0] pktLen,           // Packet length in octets
  input  wire logic       pktGfiOk,         // Format identifier correct
  input  wire logic       pktChanAssigned,  // Nonzero channel is assigned
  input  wire logic [3:0] pktGroup,         // Channel group, octet 1 bits 1 to 4
  input  wire logic [7:0] pktChan,          // Channel number, octet 2
  input  wire logic [1:0] pktType,          // Packet kind, plr_pkt_t
  input  wire logic       pktTypeShort,     // Type identifier under one octet
  input  wire logic       pktTypeUnknown,   // Type identifier not recognised
  input  wire logic       pktOverlong,      // Longer than permitted
  input  wire logic       pktTooShort,      // Shorter than its kind permits
  input  wire logic       pktMisaligned,    // Not octet aligned
  input  wire logic       confirmSent,      // Pulse, local confirmation sent in far pending
  input  wire logic       clearStart,       // Pulse, call handling sent a clear request
  input  wire logic       clearStop,        // Pulse, clear procedure answered
  input  wire logic       clearFault,       // Pulse, call handling needs a clearing fault
  input  wire logic       resetStart,       // Pulse, reset request sent in data transfer
  input  wire logic       resetStop,        // Pulse, reset procedure answered
  output logic [2:0]      restartState,     // Current restart state, one-hot
  output logic            passOn,           // Pulse, packet goes to call handling
  output logic            dropPulse,        // Pulse, packet silently discarded
  output logic            sendRestart,      // Pulse, transmit restart indication
  output logic [7:0]      restartCause,     // Cause carried by restart indication
  output logic [7:0]      restartDiag,      // Diagnostic carried by restart indication
  output logic            restartDone,      // Pulse, channels return to ready states
  output logic            sendClear,        // Pulse, transmit clear request
  output logic            clearLocalPend,   // Pulse, enter local clear pending
  output logic            clearAbandon,     // Pulse, clear without transmitting
  output logic            resetExpired      // Pulse, reset may complete
);

  plr_state_t  state_ff;
  plr_state_t  nxt_state;
  plr_action_t nxt_act;
  logic [7:0]  nxt_diag;
  logic [7:0]  diag_ff;
  logic        passOn_ff;
  logic        drop_ff;
  logic        sendRestart_ff;
  logic        done_ff;
  logic        sendClear_ff;
  logic        clearPend_ff;
  logic        zeroChan;
  logic        badType;
  logic        isRestart;
  logic        shapeBad;
  logic [7:0]  shapeDiag;
  logic [7:0]  typeDiag;
  logic        complete;
  logic [2:0]  tmStart;
  logic [2:0]  tmStop;
  logic [2:0]  tmFirst;
  logic [2:0]  tmSecond;

  // ****************************************
  // Packet classification
  // ****************************************
  assign zeroChan  = (pktGroup == `PLR_LCGN_ZERO) && (pktChan == `PLR_LCN_ZERO);
  assign badType   = pktTypeShort || pktTypeUnknown;
  assign isRestart = !badType && (pktType != PLR_PKT_OTHER);
  assign shapeBad  = pktOverlong || pktTooShort || pktMisaligned;
  assign shapeDiag = pktOverlong ? `PLR_DIAG_OVERLONG :
                     pktTooShort ? `PLR_DIAG_SHORT : `PLR_DIAG_MISALIGN;
  assign typeDiag  = pktTypeShort ? `PLR_DIAG_SHORT : `PLR_DIAG_UNKNOWN;

  // ****************************************
  // Receive decision
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    nxt_act   = PLR_ACT_NONE;
    nxt_diag  = diag_ff;
    if (pktValid)
    begin
      if (pktLen < `PLR_MIN_LEN)
        nxt_act = PLR_ACT_DROP;
      else if (!pktGfiOk || (!zeroChan && !pktChanAssigned))
        nxt_act = PLR_ACT_DROP;
      else if (zeroChan && !isRestart)
        nxt_act = PLR_ACT_DROP;
      else
      begin
        case (state_ff)
          PLR_READY:
          begin
            if (!zeroChan)
              nxt_act = PLR_ACT_PASS;
            else if (pktType == PLR_PKT_RESTART_REQ && shapeBad)
            begin
              nxt_act  = PLR_ACT_FAULT;
              nxt_diag = shapeDiag;
            end
            else if (pktType == PLR_PKT_RESTART_REQ)
            begin
              nxt_act   = PLR_ACT_PASS;
              nxt_state = PLR_FAR_PEND;
            end
            else
            begin
              nxt_act  = PLR_ACT_FAULT;
              nxt_diag = `PLR_DIAG_CONF_READY;
            end
          end
          PLR_FAR_PEND:
          begin
            nxt_act = PLR_ACT_FAULT;
            if (!zeroChan && isRestart)
              nxt_diag = `PLR_DIAG_CHANNEL;
            else if (!zeroChan && badType)
              nxt_diag = typeDiag;
            else if (!zeroChan)
              nxt_diag = `PLR_DIAG_FAR_PEND;
            else if (pktType == PLR_PKT_RESTART_REQ)
              nxt_act = PLR_ACT_DROP;
            else
              nxt_diag = `PLR_DIAG_FAR_PEND;
          end
          PLR_LOCAL_PEND:
          begin
            if (!zeroChan)
              nxt_act = PLR_ACT_DROP;
            else if (shapeBad)
            begin
              nxt_act  = PLR_ACT_FAULT;
              nxt_diag = shapeDiag;
            end
            else
            begin
              nxt_act   = PLR_ACT_PASS;
              nxt_state = PLR_READY;
            end
          end
          default:
            nxt_act = PLR_ACT_DROP;
        endcase
      end
      if (nxt_act == PLR_ACT_FAULT)
        nxt_state = PLR_LOCAL_PEND;
    end
    else if (state_ff == PLR_FAR_PEND && confirmSent)
      nxt_state = PLR_READY;
    else if (state_ff == PLR_LOCAL_PEND && tmSecond[0])
      nxt_state = PLR_READY;
  end

  assign complete = (state_ff != PLR_READY) && (nxt_state == PLR_READY);

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_ff <= PLR_READY;
    else
      state_ff <= nxt_state;
  end

  // ****************************************
  // Action outputs
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      passOn_ff      <= 1'b0;
      drop_ff        <= 1'b0;
      sendRestart_ff <= 1'b0;
      diag_ff        <= `PLR_DIAG_NONE;
      done_ff        <= 1'b0;
    end
    else
    begin
      passOn_ff      <= (nxt_act == PLR_ACT_PASS);
      drop_ff        <= (nxt_act == PLR_ACT_DROP);
      sendRestart_ff <= (nxt_act == PLR_ACT_FAULT) ||
                        (state_ff == PLR_LOCAL_PEND && tmFirst[0] && !pktValid);
      diag_ff        <= nxt_diag;
      done_ff        <= complete;
    end
  end

  // ****************************************
  // Clearing fault from call handling
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sendClear_ff <= 1'b0;
      clearPend_ff <= 1'b0;
    end
    else
    begin
      sendClear_ff <= clearFault || tmFirst[1];
      clearPend_ff <= clearFault;
    end
  end

  // ****************************************
  // Supervision timers: restart, clear, reset
  // ****************************************
  assign tmStart[0] = (nxt_act == PLR_ACT_FAULT);
  assign tmStop[0]  = complete;
  assign tmStart[1] = clearStart || clearFault;
  assign tmStop[1]  = clearStop;
  assign tmStart[2] = resetStart;
  assign tmStop[2]  = resetStop;

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_timer
      plr_timer #(
        .PERIOD ((i == 0) ? RESTART_CYCLES : (i == 1) ? CLEAR_CYCLES : RESET_CYCLES)
      ) u_timer (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .start     (tmStart[i]),
        .stop      (tmStop[i]),
        .expFirst  (tmFirst[i]),
        .expSecond (tmSecond[i])
      );
    end
  endgenerate

  assign restartState   = state_ff;
  assign passOn         = passOn_ff;
  assign dropPulse      = drop_ff;
  assign sendRestart    = sendRestart_ff;
  assign restartCause   = CONGESTION_CAUSE;
  assign restartDiag    = diag_ff;
  assign restartDone    = done_ff;
  assign sendClear      = sendClear_ff;
  assign clearLocalPend = clearPend_ff;
  assign clearAbandon   = tmSecond[1];
  assign resetExpired   = tmFirst[2];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_short_drop: assert property (pktValid && pktLen < `PLR_MIN_LEN |=>
    dropPulse && !sendRestart && $stable(restartState))
    else $error("short packet not dropped");
  a_gfi_drop: assert property (pktValid && pktLen >= `PLR_MIN_LEN && !pktGfiOk |=>
    dropPulse && !passOn)
    else $error("bad format identifier not dropped");
  a_zero_other: assert property (pktValid && pktLen >= `PLR_MIN_LEN && pktGfiOk
    && zeroChan && !isRestart |=> dropPulse && $stable(restartState))
    else $error("zero-channel non-restart not dropped");
  a_ready_req: assert property (state_ff == PLR_READY && pktValid && nxt_act ==
    PLR_ACT_PASS && zeroChan |=> restartState == PLR_FAR_PEND && !sendRestart)
    else $error("restart request in ready mishandled");
  a_conf_ready: assert property (state_ff == PLR_READY && pktValid && pktGfiOk &&
    pktLen >= `PLR_MIN_LEN && zeroChan && isRestart && pktType == PLR_PKT_RESTART_CONF
    |=> sendRestart && restartDiag == 8'h11 && restartState == PLR_LOCAL_PEND)
    else $error("confirmation in ready gave wrong fault");
  a_far_chan: assert property (state_ff == PLR_FAR_PEND && pktValid && pktGfiOk &&
    pktLen >= `PLR_MIN_LEN && !zeroChan && pktChanAssigned && isRestart
    |=> sendRestart && restartDiag == 8'h29)
    else $error("nonzero restart in far pending not 41");
  a_far_traffic: assert property (state_ff == PLR_FAR_PEND && pktValid && pktGfiOk
    && pktLen >= `PLR_MIN_LEN && !zeroChan && pktChanAssigned && !badType &&
    pktType == PLR_PKT_OTHER |=> restartDiag == 8'h12 && restartState == PLR_LOCAL_PEND)
    else $error("traffic in far pending not 18");
  a_local_shape: assert property (state_ff == PLR_LOCAL_PEND && pktValid && pktGfiOk
    && pktLen >= `PLR_MIN_LEN && zeroChan && isRestart && pktOverlong
    |=> sendRestart && restartDiag == 8'h27 && restartState == PLR_LOCAL_PEND)
    else $error("overlong restart in local pending not 39");
  a_fault_cause: assert property (nxt_act == PLR_ACT_FAULT |=>
    sendRestart && restartCause == CONGESTION_CAUSE && !passOn && !dropPulse)
    else $error("fault without restart indication");
  a_second_exp: assert property (state_ff == PLR_LOCAL_PEND && tmSecond[0] && !pktValid
    |=> restartState == PLR_READY && !sendRestart && restartDone)
    else $error("second restart expiry mishandled");
  a_done_ready: assert property ($rose(restartDone) |->
    restartState == PLR_READY && $past(restartState) != PLR_READY)
    else $error("completion pulse outside completion");

  c_far_pass: cover property (state_ff == PLR_READY ##1 state_ff == PLR_FAR_PEND
    ##[1:20] state_ff == PLR_READY);
  c_fault: cover property (sendRestart && restartState == PLR_LOCAL_PEND);
  c_retry: cover property (tmFirst[0] && state_ff == PLR_LOCAL_PEND);
  c_clear_abandon: cover property (clearAbandon);

endmodule

// file: plr_restart_map.svh
// Offsets-free constant map: diagnostic codes, timing figures and field limits
`ifndef PLR_RESTART_MAP_SVH
`define PLR_RESTART_MAP_SVH

// ****************************************
// Clock and supervision times
// ****************************************
`define PLR_CLK_HZ           25000000
`define PLR_RESTART_TIME_MS  100
`define PLR_CLEAR_TIME_MS    100
`define PLR_RESET_TIME_MS    100

// ****************************************
// Packet screening
// ****************************************
`define PLR_MIN_LEN          8'h02
`define PLR_LCGN_ZERO        4'h0
`define PLR_LCN_ZERO         8'h00

// ****************************************
// Decimal diagnostic values
// ****************************************
`define PLR_DIAG_CONF_READY  8'h11
`define PLR_DIAG_FAR_PEND    8'h12
`define PLR_DIAG_UNKNOWN     8'h21
`define PLR_DIAG_SHORT       8'h26
`define PLR_DIAG_OVERLONG    8'h27
`define PLR_DIAG_CHANNEL     8'h29
`define PLR_DIAG_MISALIGN    8'h52
`define PLR_DIAG_NONE        8'h00

`endif

// file: plr_timer.sv
// Supervision timer that reports a first and a second expiry
`timescale 1ns/1ps

module plr_timer
  import plr_pkg::*;
#(
  parameter int unsigned PERIOD = 32'd1000
)
(
  input  wire logic clk_sys,      // System clock
  input  wire logic reset,        // Synchronous reset, active high
  input  wire logic start,        // Arm from zero, first round
  input  wire logic stop,         // Disarm
  output logic      expFirst,     // One-cycle pulse, first expiry
  output logic      expSecond     // One-cycle pulse, second expiry
);

  logic [31:0] count_ff;
  logic        running_ff;
  logic        second_ff;
  logic        expFirst_ff;
  logic        expSecond_ff;
  logic        tick;

  assign tick = running_ff && (count_ff == PERIOD - 32'd1);

  // ****************************************
  // Counter and expiry round
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset || stop)
    begin
      count_ff   <= 32'h0;
      running_ff <= 1'b0;
      second_ff  <= 1'b0;
    end
    else if (start)
    begin
      count_ff   <= 32'h0;
      running_ff <= 1'b1;
      second_ff  <= 1'b0;
    end
    else if (tick)
    begin
      count_ff   <= 32'h0;
      running_ff <= !second_ff;
      second_ff  <= 1'b1;
    end
    else if (running_ff)
    begin
      count_ff <= count_ff + 32'd1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      expFirst_ff  <= 1'b0;
      expSecond_ff <= 1'b0;
    end
    else
    begin
      expFirst_ff  <= tick && !second_ff && !start && !stop;
      expSecond_ff <= tick && second_ff && !start && !stop;
    end
  end

  assign expFirst  = expFirst_ff;
  assign expSecond = expSecond_ff;

endmodule

// file: test_packet_layer_restart_fsm.sv
// Self-checking testbench of the packet-layer restart block
`timescale 1ns/1ps
`include "plr_restart_map.svh"
module test_packet_layer_restart_fsm
  import plr_pkg::*;
;
  localparam int RC = 20;
  localparam int CC = 10;
  localparam int TC = 8;
  localparam logic [2:0] PASS = 3'b001;
  localparam logic [2:0] DROP = 3'b010;
  localparam logic [2:0] FLT  = 3'b100;
  logic       clk_sys;
  logic       reset;
  logic [5:0] ctl;
  logic       autoConfirm;
  logic [3:0] answerDelay;
  logic       lastSeen;
  wire        pktValid;
  wire [7:0]  pktLen;
  wire [3:0]  pktGroup;
  wire [7:0]  pktChan;
  wire [1:0]  pktType;
  wire [6:0]  pktFlags;
  logic [2:0] restartState;
  logic       passOn, dropPulse, sendRestart, restartDone;
  logic       sendClear, clearLocalPend, clearAbandon, resetExpired;
  logic [7:0] restartCause, restartDiag;
  int         n_mismatch = 0;
  int         checks_done = 0;

  plr_far_terminal far (.clk_sys(clk_sys), .sendRestart(sendRestart),
    .autoConfirm(autoConfirm), .answerDelay(answerDelay), .pktValid(pktValid),
    .pktLen(pktLen), .pktGroup(pktGroup), .pktChan(pktChan), .pktType(pktType),
    .pktFlags(pktFlags));

  plr_restart_fsm #(.RESTART_CYCLES(RC), .CLEAR_CYCLES(CC), .RESET_CYCLES(TC)) dut (
    .clk_sys(clk_sys), .reset(reset), .pktValid(pktValid), .pktLen(pktLen),
    .pktGfiOk(~pktFlags[6]), .pktChanAssigned(~pktFlags[5]), .pktGroup(pktGroup),
    .pktChan(pktChan), .pktType(pktType), .pktTypeShort(pktFlags[4]),
    .pktTypeUnknown(pktFlags[3]), .pktOverlong(pktFlags[2]), .pktTooShort(pktFlags[1]),
    .pktMisaligned(pktFlags[0]), .confirmSent(ctl[0]), .clearStart(ctl[1]),
    .clearStop(ctl[2]), .clearFault(ctl[3]), .resetStart(ctl[4]), .resetStop(ctl[5]),
    .restartState(restartState), .passOn(passOn), .dropPulse(dropPulse),
    .sendRestart(sendRestart), .restartCause(restartCause), .restartDiag(restartDiag),
    .restartDone(restartDone), .sendClear(sendClear), .clearLocalPend(clearLocalPend),
    .clearAbandon(clearAbandon), .resetExpired(resetExpired));

  // ****************************************
  // Compare, report and bus tasks
  // ****************************************
  task automatic chkBits(input string what, input logic [2:0] exp, input logic [2:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chkCode(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic rx(input logic [7:0] len, input logic [1:0] nz, input logic [1:0] typ,
    input logic [6:0] flg, input logic [2:0] act, input logic [2:0] st, input logic [7:0] d);
    far.send(len, nz[0] ? 4'h3 : 4'h0, nz[1] ? 8'hA5 : 8'h00, typ, flg);
    #1;
    chkBits("action", act, {sendRestart, dropPulse, passOn});
    chkBits("state", st, restartState);
    if (act == FLT)
    begin
      chkCode("diag", d, restartDiag);
      chkCode("cause", 8'h05, restartCause);
    end
  endtask

  task automatic pulse(input int sel);
    @(posedge clk_sys);
    ctl[sel] <= 1'b1;
    @(posedge clk_sys);
    ctl[sel] <= 1'b0;
    #1;
  endtask

  function automatic logic sig(input int sel);
    case (sel)
      0: return sendRestart;
      1: return restartState === PLR_READY;
      2: return sendClear;
      3: return clearAbandon;
      default: return resetExpired;
    endcase
  endfunction

  // Odd selections also note whether the retransmit pulse before them shows up
  task automatic waitFor(input int sel, input int lo, input int hi, input string what);
    int n;
    n = 0;
    lastSeen = 1'b0;
    while (sig(sel) !== 1'b1 || n == 0)
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (sel % 2 == 1)
        lastSeen = lastSeen | sig(sel - 1);
      if (n > hi + 4)
      begin
        n_mismatch++;
        $display("CHECK FAILED %s expected pulse seen none", what);
        results();
      end
    end
    chkBits(what, 3'b001, {2'b00, (n >= lo) && (n <= hi)});
  endtask

  task automatic recover(input logic [1:0] typ);
    rx(8'h03, 2'd0, typ, 7'h00, PASS, PLR_READY, 8'h00);
    chkBits("done", 3'b001, {2'b00, restartDone});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_screen;
    rx(8'h01, 2'd1, PLR_PKT_OTHER, 7'h00, DROP, PLR_READY, 8'h00);
    rx(8'h02, 2'd1, PLR_PKT_OTHER, 7'h00, PASS, PLR_READY, 8'h00);
    rx(8'h03, 2'd2, PLR_PKT_OTHER, 7'h40, DROP, PLR_READY, 8'h00);
    rx(8'h03, 2'd2, PLR_PKT_OTHER, 7'h20, DROP, PLR_READY, 8'h00);
    rx(8'h03, 2'd0, PLR_PKT_OTHER, 7'h00, DROP, PLR_READY, 8'h00);
    rx(8'h03, 2'd0, PLR_PKT_OTHER, 7'h18, DROP, PLR_READY, 8'h00);
    rx(8'h03, 2'd0, PLR_PKT_RESTART_REQ, 7'h20, PASS, PLR_FAR_PEND, 8'h00);
    pulse(0);
    chkBits("state", PLR_READY, restartState);
    $display("Test screen done");
  endtask

  task automatic t_shape;
    logic [6:0] flg;
    logic [7:0] d;
    for (int i = 0; i < 3; i++)
    begin
      flg = 7'h04 >> i;
      d = (i == 0) ? 8'h27 : (i == 1) ? 8'h26 : 8'h52;
      rx(8'h03, 2'd0, PLR_PKT_RESTART_REQ, flg, FLT, PLR_LOCAL_PEND, d);
      rx(8'h03, 2'd1, PLR_PKT_OTHER, 7'h00, DROP, PLR_LOCAL_PEND, 8'h00);
      rx(8'h03, 2'd0, PLR_PKT_RESTART_CONF, flg, FLT, PLR_LOCAL_PEND, d);
      rx(8'h03, 2'd0, PLR_PKT_OTHER, 7'h00, DROP, PLR_LOCAL_PEND, 8'h00);
      recover((i == 1) ? PLR_PKT_RESTART_REQ : PLR_PKT_RESTART_CONF);
    end
    $display("Test shape done");
  endtask

  task automatic t_far;
    logic [18:0] tab [6];
    tab = '{{2'd1, PLR_PKT_RESTART_REQ, 7'h00, 8'h29}, {2'd2, PLR_PKT_RESTART_CONF, 7'h00, 8'h29},
            {2'd1, PLR_PKT_OTHER, 7'h18, 8'h26}, {2'd2, PLR_PKT_OTHER, 7'h08, 8'h21},
            {2'd3, PLR_PKT_OTHER, 7'h00, 8'h12}, {2'd0, PLR_PKT_RESTART_CONF, 7'h00, 8'h12}};
    for (int i = 0; i < 6; i++)
    begin
      rx(8'h03, 2'd0, PLR_PKT_RESTART_REQ, 7'h00, PASS, PLR_FAR_PEND, 8'h00);
      rx(8'h03, 2'd0, PLR_PKT_RESTART_REQ, 7'h00, DROP, PLR_FAR_PEND, 8'h00);
      rx(8'h03, tab[i][18:17], tab[i][16:15], tab[i][14:8], FLT, PLR_LOCAL_PEND,
         tab[i][7:0]);
      recover(PLR_PKT_RESTART_CONF);
    end
    rx(8'h03, 2'd0, PLR_PKT_RESTART_CONF, 7'h00, FLT, PLR_LOCAL_PEND, 8'h11);
    recover(PLR_PKT_RESTART_REQ);
    $display("Test far done");
  endtask

  task automatic t_timers;
    rx(8'h03, 2'd0, PLR_PKT_RESTART_CONF, 7'h00, FLT, PLR_LOCAL_PEND, 8'h11);
    waitFor(0, RC - 2, RC + 4, "restart retry");
    waitFor(1, RC - 2, RC + 4, "restart complete");
    chkBits("resend", 3'b000, {2'b00, lastSeen});
    chkBits("done", 3'b001, {2'b00, restartDone});
    pulse(3);
    chkBits("clear fault", 3'b011, {1'b0, sendClear, clearLocalPend});
    pulse(2);
    pulse(1);
    waitFor(2, CC - 2, CC + 4, "clear retry");
    waitFor(3, CC - 2, CC + 4, "clear abandon");
    chkBits("clear resend", 3'b000, {2'b00, lastSeen});
    pulse(1);
    pulse(2);
    lastSeen = 1'b0;
    repeat (3 * CC)
    begin
      @(posedge clk_sys);
      #1;
      lastSeen = lastSeen | sendClear | clearAbandon;
    end
    chkBits("clear cancel", 3'b000, {2'b00, lastSeen});
    pulse(4);
    waitFor(4, TC - 2, TC + 4, "reset expiry");
    pulse(5);
    $display("Test timers done");
  endtask

  task automatic t_partner;
    for (int i = 0; i < 2; i++)
    begin
      autoConfirm <= 1'b1;
      answerDelay <= (i == 0) ? 4'd1 : 4'd6;
      rx(8'h03, 2'd0, PLR_PKT_RESTART_CONF, 7'h00, FLT, PLR_LOCAL_PEND, 8'h11);
      waitFor(1, 2, 12, "peer answer");
      autoConfirm <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    $display("Test partner done");
  endtask

  // ****************************************
  // Clock, reset and main sequence
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial
  begin
    reset = 1'b1;
    ctl = 6'h00;
    autoConfirm = 1'b0;
    answerDelay = 4'd1;
    lastSeen = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chkBits("reset state", PLR_READY, restartState);
    chkCode("reset diag", 8'h00, restartDiag);
    t_screen();
    t_shape();
    t_far();
    t_timers();
    t_partner();
    results();
  end

  initial
  begin
    #2000000;
    n_mismatch++;
    results();
  end
endmodule
